// *** rtl/cgc_top.sv ***
// control and status logic of a clock generator: oscillator enables,
// clock select, clock monitor flag and interrupt, trim and oscillator settings
// assumes one 100 MHz bus clock, synchronous reset, and analog status pins
// that arrive from outside this clock domain
`timescale 1ns/1ps
`default_nettype none
`include "cgc_map.svh"

// Function
// - irq when enable and fail both set
// - irq enable settable after monitor on
// - fail set on inactive clock when monitoring
// - fail cleared by read then zero write
// - monitor on needs both gens enabled, stable
// - monitor on forced by fail, enables
// - select one picks external, zero internal
// - select changes need target source stable
// - select forced by inactive source while monitoring, or by disabled source
// - internal enable clear needs select, monitor off
// - internal stable tracks in-range, cleared by events
// - external enable clear needs select, monitor clear
// - external stable after 4096 external cycles
// - multiplier zero acts as one
// - multiplier locked while monitoring, resets 21
// - trim step lowers frequency 0.195 percent
// - trim locked while monitoring, resets midpoint
// - divider output saturates at nine, field reads back as written
// - divider owned by loop while internal on
// - stage field sets oscillator stage count
// - stage owned by loop while internal on
// - slow option sets monitor expectation
module cgc_top (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic EXTERNAL_CLOCK,
    input wire logic INT_CLK_INACTIVE,
    input wire logic EXT_CLK_INACTIVE,
    input wire logic INT_CLK_IN_RANGE,
    input wire logic SLOW_EXTERNAL_OPTION,
    input wire cgc_pkg::cgc_loop_s LOOP_IN,
    output logic MONITOR_IRQ,
    output logic MONITOR_ON,
    output logic MONITOR_EXPECT_SLOW,
    output logic CLK_SELECT,
    output logic INT_GEN_ENABLE,
    output logic EXT_GEN_ENABLE,
    output logic [6:0] MULT_FACTOR,
    output logic [7:0] TRIM_FACTOR,
    output logic [3:0] DIV_STAGES,
    output logic [7:0] OSC_STAGE_COUNT
);
    import cgc_pkg::*;

    cgc_state_s r_q; // registered state
    cgc_state_s r_d; // next state

    // zero multiplier behaves as one
    function automatic logic [6:0] eff_mult(input logic [6:0] m);
        eff_mult = (m == 7'h00) ? 7'h01 : m;
    endfunction

    // divider values above nine act as nine
    function automatic logic [3:0] sat_div(input logic [3:0] d);
        sat_div = (d > `CGC_DIV_MAX) ? `CGC_DIV_MAX : d;
    endfunction

    // read mux over the register map
    function automatic logic [7:0] read_reg(input cgc_state_s s, input logic [7:0] a);
        if (a == `CGC_ADDR_CTRL) begin
            read_reg = s.ctrl;
        end else if (a == `CGC_ADDR_MULT) begin
            read_reg = {1'b0, s.mult};
        end else if (a == `CGC_ADDR_TRIM) begin
            read_reg = s.trim;
        end else if (a == `CGC_ADDR_DIV) begin
            read_reg = {4'h0, s.div};
        end else if (a == `CGC_ADDR_STAGE) begin
            read_reg = s.stage;
        end else begin
            // unmapped addresses read as zero
            read_reg = `CGC_READ_NONE;
        end
    endfunction

    // next-state logic for the whole block
    always_comb begin
        logic wr_ctrl;    // write to control register
        logic wr_mult;    // accepted multiplier write
        logic wr_trim;    // accepted trim write
        logic int_dead;   // internal clock inactive, synchronised
        logic ext_dead;   // external clock inactive, synchronised
        logic ext_edge;   // rising external clock edge
        cgc_ctrl_s c;     // current control bits
        cgc_ctrl_s p;     // control bits one edge old
        cgc_ctrl_s n;     // control bits being built
        wr_ctrl = 1'b0;
        wr_mult = 1'b0;
        wr_trim = 1'b0;
        int_dead = 1'b0;
        ext_dead = 1'b0;
        ext_edge = 1'b0;
        c = r_q.ctrl;
        p = r_q.prev;
        n = r_q.ctrl;
        r_d = r_q;

        // pin synchronisers; the second stage is looked at, the third too for the external clock
        r_d.int_dead_s = {r_q.int_dead_s[0], INT_CLK_INACTIVE};
        r_d.ext_dead_s = {r_q.ext_dead_s[0], EXT_CLK_INACTIVE};
        r_d.in_range_s = {r_q.in_range_s[0], INT_CLK_IN_RANGE};
        r_d.slow_s = {r_q.slow_s[0], SLOW_EXTERNAL_OPTION};
        r_d.ext_pipe = {r_q.ext_pipe[1:0], EXTERNAL_CLOCK};
        r_d.loop_s1 = LOOP_IN;
        r_d.loop_s2 = r_q.loop_s1;
        int_dead = r_q.int_dead_s[1];
        ext_dead = r_q.ext_dead_s[1];
        // edge seen between second and third stage
        ext_edge = r_q.ext_pipe[1] & ~r_q.ext_pipe[2];

        // address decode of writes
        if (WR && ADDR == `CGC_ADDR_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (WR && ADDR == `CGC_ADDR_MULT) begin
            wr_mult = ~c.mon_on;
        end else if (WR && ADDR == `CGC_ADDR_TRIM) begin
            wr_trim = ~c.mon_on;
        end

        // software requests on the control bits, gated by permissions
        if (wr_ctrl) begin
            if (WDATA[`CGC_BIT_IRQ_EN] && p.mon_on) begin
                n.irq_en = 1'b1;
            end else if (!WDATA[`CGC_BIT_IRQ_EN]) begin
                n.irq_en = 1'b0;
            end
            if (WDATA[`CGC_BIT_MON_ON] && p.int_en && p.ext_en
                && p.int_stable && p.ext_stable) begin
                n.mon_on = 1'b1;
            end else if (!WDATA[`CGC_BIT_MON_ON]) begin
                n.mon_on = 1'b0;
            end
            if (WDATA[`CGC_BIT_SEL] && p.ext_en && p.ext_stable) begin
                n.sel = 1'b1;
            end else if (!WDATA[`CGC_BIT_SEL] && p.int_en && p.int_stable) begin
                n.sel = 1'b0;
            end
            // internal clear needs select set, external clear needs select clear; both need monitor off
            if (WDATA[`CGC_BIT_INT_EN]) begin
                n.int_en = 1'b1;
            end else if (p.sel && !p.mon_on) begin
                n.int_en = 1'b0;
            end
            if (WDATA[`CGC_BIT_EXT_EN]) begin
                n.ext_en = 1'b1;
            end else if (!p.sel && !p.mon_on) begin
                n.ext_en = 1'b0;
            end
        end

        // read of a set flag arms the clear
        if (RD && ADDR == `CGC_ADDR_CTRL && c.fail) begin
            r_d.fail_armed = 1'b1;
        end
        if (wr_ctrl) begin
            // armed zero write clears the flag
            if (!WDATA[`CGC_BIT_FAIL] && r_q.fail_armed) begin
                n.fail = 1'b0;
            end
            r_d.fail_armed = 1'b0;
        end
        // monitor catches an inactive clock; set wins over clear
        if (c.mon_on && (int_dead || ext_dead)) begin
            n.fail = 1'b1;
        end

        if (n.fail) begin
            n.mon_on = 1'b1;
        end
        if (n.mon_on || !n.sel) begin
            n.int_en = 1'b1;
        end
        if (n.mon_on || n.sel) begin
            n.ext_en = 1'b1;
        end
        // fallback to external when internal dies while monitoring, or internal is off
        if ((c.mon_on && int_dead) || !n.int_en) begin
            n.sel = 1'b1;
        end
        // fallback to internal when external dies while monitoring, or external is off
        if ((c.mon_on && ext_dead) || !n.ext_en) begin
            n.sel = 1'b0;
        end
        if (!n.sel) begin
            n.int_en = 1'b1;
        end
        // monitor off when a generator is off
        if (!n.int_en || !n.ext_en) begin
            n.mon_on = 1'b0;
        end
        if (!n.mon_on) begin
            n.fail = 1'b0;
            r_d.fail_armed = 1'b0;
        end
        if (!n.mon_on) begin
            n.irq_en = 1'b0;
        end

        // in-range flag, dropped by a new multiplier or trim
        n.int_stable = r_q.in_range_s[1] & n.int_en & ~(c.mon_on & int_dead)
            & ~wr_mult & ~wr_trim;

        // count external edges from the enable
        if (!n.ext_en || (c.mon_on && ext_dead)) begin
            r_d.ext_count = 13'h0000;
        end else if (ext_edge && r_q.ext_count != `CGC_EXT_START_CYCLES) begin
            r_d.ext_count = r_q.ext_count + 13'h0001;
        end
        n.ext_stable = (r_d.ext_count == `CGC_EXT_START_CYCLES);

        if (wr_mult) begin
            r_d.mult = WDATA[6:0];
        end
        if (wr_trim) begin
            r_d.trim = WDATA;
        end

        // loop filter owns the oscillator fields while internal enable is set; otherwise a write sets them
        if (n.int_en) begin
            r_d.div = r_q.loop_s2.div;
            r_d.stage = r_q.loop_s2.stage;
        end else if (WR && ADDR == `CGC_ADDR_DIV) begin
            r_d.div = WDATA[3:0];
        end else if (WR && ADDR == `CGC_ADDR_STAGE) begin
            r_d.stage = WDATA;
        end

        r_d.ctrl = n;
        // copy checked by the next write
        r_d.prev = r_q.ctrl;

        // read data valid in the cycle after the strobe only
        r_d.rdata = RD ? read_reg(r_q, ADDR) : `CGC_READ_NONE;

        // registered outputs
        // request from enable and flag
        r_d.irq = n.irq_en & n.fail;
        r_d.mult_eff = eff_mult(r_d.mult);
        r_d.div_eff = sat_div(r_d.div);
        r_d.expect_slow = r_q.slow_s[1];

        // synchronous reset; divider and stage fields are not cleared and still follow the loop or a write
        if (RST) begin
            r_d.ctrl = '0;
            r_d.ctrl.int_en = 1'b1;
            r_d.prev = '0;
            r_d.fail_armed = 1'b0;
            r_d.mult = `CGC_RST_MULT;
            r_d.trim = `CGC_RST_TRIM;
            r_d.ext_count = 13'h0000;
            r_d.ext_pipe = 3'h0;
            r_d.int_dead_s = 2'h0;
            r_d.ext_dead_s = 2'h0;
            r_d.in_range_s = 2'h0;
            r_d.slow_s = 2'h0;
            r_d.loop_s1 = '0;
            r_d.loop_s2 = '0;
            r_d.rdata = `CGC_READ_NONE;
            r_d.irq = 1'b0;
            r_d.mult_eff = `CGC_RST_MULT;
            r_d.div_eff = sat_div(r_q.div);
            r_d.expect_slow = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge CLOCK) begin
        r_q <= r_d;
    end

    // outputs straight from flip-flops
    assign RDATA = r_q.rdata;
    assign MONITOR_IRQ = r_q.irq;
    assign MONITOR_ON = r_q.ctrl.mon_on;
    assign MONITOR_EXPECT_SLOW = r_q.expect_slow;
    assign CLK_SELECT = r_q.ctrl.sel;
    assign INT_GEN_ENABLE = r_q.ctrl.int_en;
    assign EXT_GEN_ENABLE = r_q.ctrl.ext_en;
    assign MULT_FACTOR = r_q.mult_eff;
    assign TRIM_FACTOR = r_q.trim;
    assign DIV_STAGES = r_q.div_eff;
    assign OSC_STAGE_COUNT = r_q.stage;

endmodule
`default_nettype wire

// *** shared/cgc_map.svh ***
// register map, field positions, reset values and counts of the clock generator control
// assumes an 8-bit register port with byte addresses as printed
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH

// register byte addresses
`define CGC_ADDR_CTRL 8'h36
`define CGC_ADDR_MULT 8'h37
`define CGC_ADDR_TRIM 8'h38
`define CGC_ADDR_DIV 8'h39
`define CGC_ADDR_STAGE 8'h3A

// control register bit positions
`define CGC_BIT_IRQ_EN 7
`define CGC_BIT_FAIL 6
`define CGC_BIT_MON_ON 5
`define CGC_BIT_SEL 4
`define CGC_BIT_INT_EN 3
`define CGC_BIT_INT_STABLE 2
`define CGC_BIT_EXT_EN 1
`define CGC_BIT_EXT_STABLE 0

// reset values
`define CGC_RST_MULT 7'h15
`define CGC_RST_TRIM 8'h80

// limits and counts
`define CGC_DIV_MAX 4'h9
`define CGC_EXT_START_CYCLES 13'h1000
`define CGC_READ_NONE 8'h00

`endif

// *** shared/cgc_pkg.sv ***
// types shared by the clock generator control block
// assumes cgc_map.svh is on the include path
package cgc_pkg;

    // software-visible control bits plus their one-cycle-old copy
    typedef struct packed {
        logic irq_en;     // monitor_irq_enable
        logic fail;       // monitor_fail_flag
        logic mon_on;     // monitor_on
        logic sel;        // clock select, 1 = external
        logic int_en;     // internal_gen_enable
        logic int_stable; // internal_gen_stable
        logic ext_en;     // external_gen_enable
        logic ext_stable; // external_gen_stable
    } cgc_ctrl_s;

    // values handed over by the digital loop filter
    typedef struct packed {
        logic [3:0] div;   // divider_stages
        logic [7:0] stage; // oscillator_stage_count
    } cgc_loop_s;

    // whole state of the block
    typedef struct packed {
        cgc_ctrl_s ctrl;           // control register
        cgc_ctrl_s prev;           // copy sampled one edge earlier
        logic fail_armed;          // fail flag seen set by a read
        logic [6:0] mult;          // multiplier_factor
        logic [7:0] trim;          // trim_factor
        logic [3:0] div;           // divider field as read back
        logic [7:0] stage;         // stage field
        logic [12:0] ext_count;    // external clock edges since enable
        logic [2:0] ext_pipe;      // external clock synchroniser + edge stage
        logic [1:0] int_dead_s;    // internal clock inactive sync
        logic [1:0] ext_dead_s;    // external clock inactive sync
        logic [1:0] in_range_s;    // internal clock in range sync
        logic [1:0] slow_s;        // slow external option sync
        cgc_loop_s loop_s1;        // loop filter sync, first stage
        cgc_loop_s loop_s2;        // loop filter sync, second stage
        logic [7:0] rdata;         // read data
        logic irq;                 // interrupt request out
        logic [6:0] mult_eff;      // effective multiplier out
        logic [3:0] div_eff;       // saturated divider out
        logic expect_slow;         // monitor expectation out
    } cgc_state_s;

endpackage

// *** tb/cgc_top_props.sv ***
// assertions on the port behaviour of the clock generator control block
// assumes it is bound to cgc_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
`include "cgc_map.svh"

module cgc_top_props (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic MONITOR_IRQ,
    input wire logic MONITOR_ON,
    input wire logic CLK_SELECT,
    input wire logic INT_GEN_ENABLE,
    input wire logic EXT_GEN_ENABLE,
    input wire logic [6:0] MULT_FACTOR,
    input wire logic [7:0] TRIM_FACTOR,
    input wire logic [3:0] DIV_STAGES
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    a_irq_needs_mon: assert property (
        MONITOR_IRQ |-> MONITOR_ON) else $error("irq without monitor");
    // irq is registered on the same edge as the monitor and fail bits, with no lag
    a_irq_off_clear: assert property (
        !MONITOR_ON |=> !MONITOR_IRQ) else $error("irq while monitor off");
    a_mon_needs_gens: assert property (
        MONITOR_ON |-> INT_GEN_ENABLE && EXT_GEN_ENABLE) else $error("monitor with a gen off");
    a_sel_forced_ext: assert property (
        !INT_GEN_ENABLE |-> CLK_SELECT) else $error("internal off but select internal");
    a_int_en_held: assert property (
        MONITOR_ON || !CLK_SELECT |-> INT_GEN_ENABLE) else $error("internal enable dropped");
    a_ext_en_held: assert property (
        MONITOR_ON || CLK_SELECT |-> EXT_GEN_ENABLE) else $error("external enable dropped");
    a_mult_nonzero: assert property (
        MULT_FACTOR != 7'h00) else $error("multiplier shows zero");
    // compare two cycles on so a lagging output cannot hide a change
    a_mult_locked: assert property (
        WR && ADDR == `CGC_ADDR_MULT && MONITOR_ON |-> ##2 MULT_FACTOR == $past(MULT_FACTOR, 2))
        else $error("multiplier changed while monitoring");
    a_trim_locked: assert property (
        WR && ADDR == `CGC_ADDR_TRIM && MONITOR_ON |-> ##2 TRIM_FACTOR == $past(TRIM_FACTOR, 2))
        else $error("trim changed while monitoring");
    a_trim_taken: assert property (
        WR && ADDR == `CGC_ADDR_TRIM && !MONITOR_ON |=> TRIM_FACTOR == $past(WDATA))
        else $error("trim write lost");
    a_div_saturates: assert property (
        DIV_STAGES > 4'h9 |-> 1'b0) else $error("divider above nine");

    // main scenarios reached
    c_irq: cover property (MONITOR_IRQ);
    c_int_off: cover property ($fell(INT_GEN_ENABLE));
    c_mon_ext: cover property (MONITOR_ON && CLK_SELECT);
endmodule

bind cgc_top cgc_top_props u_props (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .MONITOR_IRQ(MONITOR_IRQ), .MONITOR_ON(MONITOR_ON), .CLK_SELECT(CLK_SELECT),
    .INT_GEN_ENABLE(INT_GEN_ENABLE), .EXT_GEN_ENABLE(EXT_GEN_ENABLE),
    .MULT_FACTOR(MULT_FACTOR), .TRIM_FACTOR(TRIM_FACTOR), .DIV_STAGES(DIV_STAGES));
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the clock generator control block
// assumes cgc_pkg and cgc_map.svh are compiled first; checker comes by bind
`timescale 1ns/1ps
`default_nettype none
`include "cgc_map.svh"

module tb;
    import cgc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic ext_clk = 1'b0;
    logic int_dead = 1'b0;
    logic ext_dead = 1'b0; // external clock inactive, driven once near the end
    logic in_range = 1'b0;
    logic slow = 1'b0;
    cgc_loop_s loop_in = 12'h000;
    logic [7:0] rdata, trim, stage;
    logic irq, mon_on, exp_slow, sel, int_en, ext_en;
    logic [6:0] mult;
    logic [3:0] div;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 48481;
    bit ext_run = 1'b0; // external oscillator running
    bit ext_div = 1'b0; // halves the toggle rate of the external clock
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$]; // expected read answers, oldest first
    logic [7:0] t;
    cgc_loop_s lv;

    cgc_top u_cgc_top (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .EXTERNAL_CLOCK(ext_clk), .INT_CLK_INACTIVE(int_dead),
        .EXT_CLK_INACTIVE(ext_dead), .INT_CLK_IN_RANGE(in_range),
        .SLOW_EXTERNAL_OPTION(slow), .LOOP_IN(loop_in), .MONITOR_IRQ(irq),
        .MONITOR_ON(mon_on), .MONITOR_EXPECT_SLOW(exp_slow), .CLK_SELECT(sel),
        .INT_GEN_ENABLE(int_en), .EXT_GEN_ENABLE(ext_en), .MULT_FACTOR(mult),
        .TRIM_FACTOR(trim), .DIV_STAGES(div), .OSC_STAGE_COUNT(stage));

    // bus clock, 100 MHz
    initial begin
        forever #5 clk = ~clk;
    end
    // external oscillator at 25 MHz, stepped on bus edges like every other input
    always @(posedge clk) begin
        if (ext_run) ext_div <= ~ext_div;
        if (ext_run && ext_div) ext_clk <= ~ext_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // the expected answer is noted when the read is issued
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd_s <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // read answers stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_s;
    always @(negedge clk) begin
        if (rd_seen) chk(rdata, exp_q.pop_front());
    end

    // watchdog: the full run needs about 170 us
    initial begin
        #300000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`CGC_ADDR_CTRL, 8'h08);
        rd(`CGC_ADDR_MULT, 8'h15);
        rd(`CGC_ADDR_TRIM, 8'h80);
        rd(8'h40, 8'h00);
        // loop filter owns divider and stages while internal side runs
        for (int i = 0; i < 4; i++) begin
            lv = 12'($random(seed));
            if (i == 0) lv.div = 4'hF;
            @(posedge clk);
            loop_in <= lv;
            cyc(4);
            @(negedge clk);
            chk({4'h0, div}, (lv.div > 4'h9) ? 8'h09 : {4'h0, lv.div});
            chk(stage, lv.stage);
        end
        // look right after the refused write, before the loop could mask it
        wr(`CGC_ADDR_DIV, 8'h03);
        @(negedge clk);
        chk({4'h0, div}, (lv.div > 4'h9) ? 8'h09 : {4'h0, lv.div});
        t = 8'($random(seed));
        wr(`CGC_ADDR_MULT, 8'h00);
        @(negedge clk);
        chk({1'b0, mult}, 8'h01);
        rd(`CGC_ADDR_MULT, 8'h00);
        wr(`CGC_ADDR_MULT, 8'h15);
        wr(`CGC_ADDR_TRIM, t);
        @(negedge clk);
        chk(trim, t);
        @(posedge clk);
        in_range <= 1'b1;
        cyc(4);
        rd(`CGC_ADDR_CTRL, 8'h0C);
        // select and monitor refused until the external side is ready
        wr(`CGC_ADDR_CTRL, 8'h18);
        rd(`CGC_ADDR_CTRL, 8'h0C);
        wr(`CGC_ADDR_CTRL, 8'h0A);
        ext_run = 1'b1;
        wr(`CGC_ADDR_CTRL, 8'h2A);
        rd(`CGC_ADDR_CTRL, 8'h0E);
        repeat (4080) @(posedge ext_clk);
        rd(`CGC_ADDR_CTRL, 8'h0E);
        repeat (30) @(posedge ext_clk);
        cyc(4);
        rd(`CGC_ADDR_CTRL, 8'h0F);
        wr(`CGC_ADDR_CTRL, 8'h1A);
        rd(`CGC_ADDR_CTRL, 8'h1F);
        @(negedge clk);
        chk({7'h0, sel}, 8'h01);
        // internal side off: software now owns divider and stages
        wr(`CGC_ADDR_CTRL, 8'h12);
        rd(`CGC_ADDR_CTRL, 8'h13);
        @(negedge clk);
        chk({5'h0, mon_on, int_en, ext_en}, 8'h01);
        wr(`CGC_ADDR_DIV, 8'h0C);
        wr(`CGC_ADDR_STAGE, t);
        @(negedge clk);
        chk({4'h0, div}, 8'h09);
        chk(stage, t);
        wr(`CGC_ADDR_CTRL, 8'h10);
        rd(`CGC_ADDR_CTRL, 8'h13);
        wr(`CGC_ADDR_CTRL, 8'h1A);
        cyc(4);
        rd(`CGC_ADDR_CTRL, 8'h1F);
        wr(`CGC_ADDR_CTRL, 8'h0A);
        rd(`CGC_ADDR_CTRL, 8'h0F);
        wr(`CGC_ADDR_CTRL, 8'h2A);
        rd(`CGC_ADDR_CTRL, 8'h2F);
        wr(`CGC_ADDR_MULT, 8'h33);
        wr(`CGC_ADDR_TRIM, ~t);
        rd(`CGC_ADDR_MULT, 8'h15);
        rd(`CGC_ADDR_TRIM, t);
        wr(`CGC_ADDR_CTRL, 8'hAA);
        wr(`CGC_ADDR_CTRL, 8'hA2);
        rd(`CGC_ADDR_CTRL, 8'hAF);
        // internal clock dies while monitoring
        int_dead <= 1'b1;
        cyc(5);
        @(negedge clk);
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, sel}, 8'h01);
        chk({5'h0, mon_on, int_en, ext_en}, 8'h07);
        @(posedge clk);
        int_dead <= 1'b0;
        cyc(4);
        // a clear counts only right after a read that saw the flag
        rd(`CGC_ADDR_CTRL, 8'hFF);
        wr(`CGC_ADDR_CTRL, 8'hFA);
        wr(`CGC_ADDR_CTRL, 8'hBA);
        rd(`CGC_ADDR_CTRL, 8'hFF);
        wr(`CGC_ADDR_CTRL, 8'hBA);
        rd(`CGC_ADDR_CTRL, 8'hBF);
        wr(`CGC_ADDR_CTRL, 8'h1A);
        rd(`CGC_ADDR_CTRL, 8'h1F);
        slow <= 1'b1;
        cyc(4);
        @(negedge clk);
        chk({7'h0, exp_slow}, 8'h01);
        // external clock dies while monitoring on the external source
        wr(`CGC_ADDR_CTRL, 8'h3A);
        rd(`CGC_ADDR_CTRL, 8'h3F);
        ext_dead <= 1'b1;
        cyc(4);
        rd(`CGC_ADDR_CTRL, 8'h6E);
        @(negedge clk);
        chk({7'h0, sel}, 8'h00);
        cyc(4);
        summarize();
    end
endmodule
`default_nettype wire
